// ===== src/fnc_defines.svh
// Constants for the frame-number counters and offset mapping block.
// Assumes inclusion by bare name from the src folder.
// How it works
// - Node frame counter counts 0..4095 and wraps to 0.
// - Cell frame counter ranges 0..4095 and is output for broadcast.
// - Frequency-division: cell count is node count delayed by cell delay.
// - Time-division with sync port: cell mod 256 equals node mod 256.
// - Connection number ranges 0..255, or 0..4095 for paging channel.
// - Downward: selected cell frame low byte is connection number plus offset.
// - Upward: connection number is cell count minus offset, modulo 256.
// - Only the low 8 bits of cell count take part in offset mapping; the paging channel number takes all 12.
// - Frequency-division default offset: 512-chip steps, range 0..599.
// - Time-division default offset: 1-frame steps, range 0..7.
// - Frame offset times 38400 plus chip offset rounds to 256 chips.
`ifndef FNC_DEFINES_SVH
`define FNC_DEFINES_SVH

// ----------------------------------------------------------------
// Widths and limits
// ----------------------------------------------------------------
`define FNC_FRAME_W 12
`define FNC_FRAME_MAX 12'hfff
`define FNC_CONN_W 8
`define FNC_CHIP_W 16
`define FNC_CHIP_MAX 16'h95ff
`define FNC_CHIPS_PER_FRAME 24'h009600
`define FNC_SUM_W 24
`define FNC_ROUND_HALF 8'h80
`define FNC_DOFF_FD_W 10
`define FNC_DOFF_FD_MAX 10'h257
`define FNC_DOFF_TD_W 3
`define FNC_DOFF_TD_MAX 3'h7
`define FNC_CELL_DELAY_W 4

`endif

// ===== src/fnc_pkg.sv
// Types for the frame-number counter block.
// Assumes fnc_defines.svh is reachable by bare name.
`include "fnc_defines.svh"
package fnc_pkg;
	typedef logic [`FNC_FRAME_W-1:0] fnc_frame_t;
	typedef logic [`FNC_CONN_W-1:0] fnc_conn_t;
	typedef logic [`FNC_CHIP_W-1:0] fnc_chip_t;
	typedef logic [`FNC_SUM_W-1:0] fnc_sum_t;
	typedef enum logic {FNC_FREQ_DIV, FNC_TIME_DIV} fnc_mode_t;
endpackage

// ===== src/fnc_map_if.sv
// Carrier between the top and the offset mapper.
// Assumes fnc_pkg is compiled first.
`timescale 1ns/100ps
`default_nettype none
interface fnc_map_if;
	fnc_pkg::fnc_conn_t cell_low;
	fnc_pkg::fnc_conn_t frame_offset;
	fnc_pkg::fnc_conn_t conn_in;
	fnc_pkg::fnc_conn_t sel_low;
	fnc_pkg::fnc_conn_t conn_up;
	modport top (output cell_low, output frame_offset, output conn_in,
		input sel_low, input conn_up);
	modport mapper (input cell_low, input frame_offset, input conn_in,
		output sel_low, output conn_up);
endinterface
`default_nettype wire

// ===== src/fnc_offset_map.sv
// Modulo-256 mapping between connection numbers and cell frame counts.
// Assumes the top registers its outputs.
`timescale 1ns/100ps
`default_nettype none
module fnc_offset_map (
	fnc_map_if.mapper m
);
	import fnc_pkg::*;

	// Both directions, 8-bit wraparound arithmetic
	always_comb begin
		m.sel_low = m.conn_in + m.frame_offset;
		m.conn_up = m.cell_low - m.frame_offset;
	end
endmodule
`default_nettype wire

// ===== src/fnc_frame_counters.sv
// Node and cell frame counters with frame/chip offset handling.
// Assumes frame_tick pulses one cycle per 10 ms radio frame boundary.
`timescale 1ns/100ps
`default_nettype none
`include "fnc_defines.svh"
module fnc_frame_counters (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Timing reference and mode
	input wire logic frame_tick,
	input wire logic cell_delay_tick,
	input wire fnc_pkg::fnc_mode_t duplex_mode,
	input wire logic sync_port_used,
	input wire logic [`FNC_CELL_DELAY_W-1:0] cell_delay_steps,
	// Offsets from the serving controller
	input wire fnc_pkg::fnc_conn_t frame_offset,
	input wire fnc_pkg::fnc_chip_t chip_offset,
	input wire logic [`FNC_DOFF_FD_W-1:0] default_link_offset_freq_div,
	input wire logic [`FNC_DOFF_TD_W-1:0] default_link_offset_time_div,
	// Downward and upward requests
	input wire logic down_req,
	input wire fnc_pkg::fnc_frame_t connection_frame_number_in,
	input wire logic paging_sel,
	input wire logic up_req,
	// Counters
	output logic [`FNC_FRAME_W-1:0] node_frame_count,
	output logic [`FNC_FRAME_W-1:0] cell_frame_count,
	// Mapping results
	output logic down_valid,
	output logic [`FNC_FRAME_W-1:0] down_cell_frame,
	output logic up_valid,
	output logic [`FNC_FRAME_W-1:0] connection_frame_number,
	output logic [`FNC_SUM_W-1:0] dedicated_link_channel_timing,
	output logic offset_range_err
);
	import fnc_pkg::*;

	fnc_map_if mi ();
	fnc_frame_t node_q, node_d, cell_q, cell_d;
	fnc_frame_t dsel_q, dsel_d, conn_q, conn_d;
	logic dval_q, dval_d, uval_q, uval_d;
	logic cell_pend_q, cell_pend_d;
	logic [`FNC_CELL_DELAY_W-1:0] dly_q, dly_d;
	fnc_sum_t tim_q, tim_d, raw_sum;
	logic err_q, err_d;
	logic [7:0] cand_low;
	fnc_frame_t cand;

	// ----------------------------------------------------------------
	// Mapper instance
	// ----------------------------------------------------------------
	assign mi.cell_low = cell_q[7:0];
	assign mi.frame_offset = frame_offset;
	assign mi.conn_in = connection_frame_number_in[7:0];

	fnc_offset_map u_map (
		.m(mi.mapper)
	);

	// ----------------------------------------------------------------
	// Counter next state
	// ----------------------------------------------------------------
	always_comb begin
		node_d = node_q;
		cell_d = cell_q;
		cell_pend_d = cell_pend_q;
		dly_d = dly_q;
		if (frame_tick) begin
			node_d = node_q + 12'h001;
		end
		if (duplex_mode == FNC_FREQ_DIV) begin
			// Cell frame starts after the cell delay in 256-chip steps
			if (frame_tick) begin
				if (cell_delay_steps == '0) begin
					cell_d = cell_q + 12'h001;
				end else begin
					cell_pend_d = 1'b1;
					dly_d = cell_delay_steps;
				end
			end else if (cell_pend_q && cell_delay_tick) begin
				dly_d = dly_q - 4'h1;
				if (dly_q == 4'h1) begin
					cell_pend_d = 1'b0;
					cell_d = cell_q + 12'h001;
				end
			end
		end else begin
			cell_pend_d = 1'b0;
			if (frame_tick) begin
				cell_d = cell_q + 12'h001;
			end
			if (sync_port_used) begin
				cell_d[7:0] = node_d[7:0];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			node_q <= '0;
			cell_q <= '0;
			cell_pend_q <= 1'b0;
			dly_q <= '0;
		end else begin
			node_q <= node_d;
			cell_q <= cell_d;
			cell_pend_q <= cell_pend_d;
			dly_q <= dly_d;
		end
	end

	// ----------------------------------------------------------------
	// Mapping and timing next state
	// ----------------------------------------------------------------
	always_comb begin
		cand_low = mi.sel_low;
		// Next cell frame whose low byte matches, 4096 wrap
		if (cand_low > cell_q[7:0]) begin
			cand = {cell_q[11:8], cand_low};
		end else begin
			cand = {cell_q[11:8] + 4'h1, cand_low};
		end
		dval_d = down_req;
		dsel_d = down_req ? cand : dsel_q;
		uval_d = up_req;
		conn_d = conn_q;
		if (up_req) begin
			if (paging_sel) begin
				conn_d = cell_q;
			end else begin
				conn_d = {4'h0, mi.conn_up};
			end
		end
		// Frame offset times chips per frame plus chip offset
		raw_sum = fnc_sum_t'(frame_offset) * `FNC_CHIPS_PER_FRAME
			+ fnc_sum_t'(chip_offset);
		if (raw_sum[7:0] >= `FNC_ROUND_HALF) begin
			tim_d = {raw_sum[23:8] + 16'h0001, 8'h00};
		end else begin
			tim_d = {raw_sum[23:8], 8'h00};
		end
		err_d = (chip_offset > `FNC_CHIP_MAX)
			|| (default_link_offset_freq_div > `FNC_DOFF_FD_MAX)
			|| (default_link_offset_time_div > `FNC_DOFF_TD_MAX);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dval_q <= 1'b0;
			dsel_q <= '0;
			uval_q <= 1'b0;
			conn_q <= '0;
			tim_q <= '0;
			err_q <= 1'b0;
		end else begin
			dval_q <= dval_d;
			dsel_q <= dsel_d;
			uval_q <= uval_d;
			conn_q <= conn_d;
			tim_q <= tim_d;
			err_q <= err_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign node_frame_count = node_q;
	assign cell_frame_count = cell_q;
	assign down_valid = dval_q;
	assign down_cell_frame = dsel_q;
	assign up_valid = uval_q;
	assign connection_frame_number = conn_q;
	assign dedicated_link_channel_timing = tim_q;
	assign offset_range_err = err_q;
endmodule
`default_nettype wire

// ===== dv/fnc_ctrl_model.sv
// Serving controller model: hands offset sets to the base station.
// Assumes fnc_pkg is compiled first; idx picks the offset set.
`timescale 1ns/100ps
`default_nettype none
module fnc_ctrl_model (
	// Clock, reset, frame reference and set select
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic frame_tick,
	input wire logic [1:0] idx,
	// Controller's own frame counter
	output var fnc_pkg::fnc_frame_t controller_frame_count,
	// Offsets to the base station
	output var fnc_pkg::fnc_conn_t frame_offset,
	output var fnc_pkg::fnc_chip_t chip_offset,
	output logic [9:0] default_link_offset_freq_div,
	output logic [2:0] default_link_offset_time_div
);
	import fnc_pkg::*;
	// Controller frame counter, wraps silently at 4095
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			controller_frame_count <= '0;
		end else if (frame_tick) begin
			controller_frame_count <= controller_frame_count + 12'h001;
		end
	end
	// Offsets worked out on the controller side, applied as sent
	always_ff @(posedge sys_clk) begin
		case (idx)
		2'h0: {frame_offset, chip_offset} <= {8'h00, 16'h0000};
		2'h1: {frame_offset, chip_offset} <= {8'h05, 16'h007f};
		2'h2: {frame_offset, chip_offset} <= {8'hff, 16'h0080};
		default: {frame_offset, chip_offset} <= {8'h01, 16'h9600};
		endcase
		default_link_offset_freq_div <= (idx == 2'h3) ? 10'h258 : 10'h257;
		default_link_offset_time_div <= 3'h7;
	end
endmodule
`default_nettype wire

// ===== dv/fnc_checker.sv
// Port assertions for the frame counter top.
// Assumes one clock domain; bound below.
`timescale 1ns/100ps
`default_nettype none
module fnc_checker (
	// Clock, reset, controls
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic frame_tick,
	input wire fnc_pkg::fnc_mode_t duplex_mode,
	input wire logic sync_port_used,
	input wire fnc_pkg::fnc_conn_t frame_offset,
	input wire fnc_pkg::fnc_chip_t chip_offset,
	// Requests
	input wire logic down_req,
	input wire fnc_pkg::fnc_frame_t connection_frame_number_in,
	input wire logic paging_sel,
	input wire logic up_req,
	// Results
	input wire fnc_pkg::fnc_frame_t node_frame_count,
	input wire fnc_pkg::fnc_frame_t cell_frame_count,
	input wire logic down_valid,
	input wire fnc_pkg::fnc_frame_t down_cell_frame,
	input wire logic up_valid,
	input wire fnc_pkg::fnc_frame_t connection_frame_number,
	input wire logic offset_range_err
);
	import fnc_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Steps of counting and locking
	sequence s_at_max; frame_tick && node_frame_count == 12'hfff; endsequence
	sequence s_locked; (duplex_mode == FNC_TIME_DIV && sync_port_used)[*2]; endsequence
	property p_wrap; s_at_max |=> node_frame_count == 12'h000; endproperty
	a_wrap: assert property (p_wrap) else $error("node wrap");
	property p_step; frame_tick && node_frame_count != 12'hfff |=>
		node_frame_count == $past(node_frame_count) + 12'h001; endproperty
	a_step: assert property (p_step) else $error("node step");
	property p_hold; !frame_tick |=> $stable(node_frame_count); endproperty
	a_hold: assert property (p_hold) else $error("node hold");
	property p_down; down_req |=> down_valid && down_cell_frame[7:0] ==
		8'($past(connection_frame_number_in[7:0]) + $past(frame_offset)); endproperty
	a_down: assert property (p_down) else $error("down map");
	property p_up; up_req && !paging_sel |=> up_valid && connection_frame_number
		== {4'h0, 8'($past(cell_frame_count[7:0]) - $past(frame_offset))}; endproperty
	a_up: assert property (p_up) else $error("up map");
	property p_page; up_req && paging_sel |=>
		connection_frame_number == $past(cell_frame_count); endproperty
	a_page: assert property (p_page) else $error("paging number");
	property p_sync; s_locked |-> cell_frame_count[7:0] == node_frame_count[7:0]; endproperty
	a_sync: assert property (p_sync) else $error("sync lock");
	property p_err; chip_offset > 16'h95ff |=> offset_range_err; endproperty
	a_err: assert property (p_err) else $error("chip range");
endmodule
bind fnc_frame_counters fnc_checker chk_u (.*);
`default_nettype wire

// ===== dv/tb_frame_number_counters_and_offset_mapping.sv
// Self-checking bench for the frame counter top.
// Assumes package, interface, design and partner compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_frame_number_counters_and_offset_mapping;
	import fnc_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, frame_tick = 1'b0, cell_delay_tick = 1'b1;
	logic sync_port_used = 1'b0, down_req = 1'b0, paging_sel = 1'b0, up_req = 1'b0;
	fnc_mode_t duplex_mode = FNC_FREQ_DIV;
	logic [3:0] cell_delay_steps = 4'h0;
	logic [1:0] idx = 2'h0;
	fnc_conn_t frame_offset;
	fnc_chip_t chip_offset;
	logic [9:0] default_link_offset_freq_div;
	logic [2:0] default_link_offset_time_div;
	logic down_valid, up_valid, offset_range_err;
	fnc_frame_t connection_frame_number_in = 12'h000, node_frame_count;
	fnc_frame_t cell_frame_count, down_cell_frame, connection_frame_number;
	fnc_frame_t controller_frame_count;
	fnc_sum_t dedicated_link_channel_timing;
	int fails = 0, n_tests = 0, cyc = 0, i;
	// Rows: connection in, down frame, up number, timing, range error
	logic [56:0] rows [4] = '{{12'h0ff, 12'h0ff, 8'h00, 24'h000000, 1'h0},
		{12'h0fe, 12'h003, 8'hfb, 24'h02ee00, 1'h0},
		{12'h001, 12'h100, 8'h01, 24'h956b00, 1'h0},
		{12'hf10, 12'h011, 8'hff, 24'h012c00, 1'h1}};
	fnc_frame_counters dut_u (.*);
	fnc_ctrl_model ctrl_u (.*);
	// Clock and hang guard
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fails = fails + 1;
			report_and_stop();
		end
	end
	task automatic chk(input string name, input logic [23:0] seen,
		input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Reset, table of offset sets, then wrap, paging and lock cases
	initial begin
		repeat (16) @(posedge sys_clk);
		chk("node in reset", node_frame_count, 24'h0);
		rst <= 1'b0;
		for (i = 0; i < 4; i++) begin
			idx <= 2'(i);
			connection_frame_number_in <= rows[i][56:45];
			repeat (2) @(posedge sys_clk);
			down_req <= 1'b1;
			up_req <= 1'b1;
			@(posedge sys_clk);
			down_req <= 1'b0;
			up_req <= 1'b0;
			@(negedge sys_clk);
			chk("down valid", down_valid, 24'h1);
			chk("down frame", down_cell_frame, rows[i][44:33]);
			chk("up valid", up_valid, 24'h1);
			chk("up number", connection_frame_number, rows[i][32:25]);
			chk("timing", dedicated_link_channel_timing, rows[i][24:1]);
			chk("range err", offset_range_err, rows[i][0]);
			@(posedge sys_clk);
		end
		frame_tick <= 1'b1;
		repeat (4100) @(posedge sys_clk);
		frame_tick <= 1'b0;
		paging_sel <= 1'b1;
		up_req <= 1'b1;
		@(posedge sys_clk);
		up_req <= 1'b0;
		@(negedge sys_clk);
		chk("node wrap", node_frame_count, 24'h004);
		chk("cell count", cell_frame_count, 24'h004);
		chk("paging number", connection_frame_number, 24'h004);
		chk("ctrl count", controller_frame_count, 24'h004);
		// Cell delay of two steps holds the cell increment back
		@(posedge sys_clk);
		cell_delay_steps <= 4'h2;
		frame_tick <= 1'b1;
		@(posedge sys_clk);
		frame_tick <= 1'b0;
		@(negedge sys_clk);
		chk("cell delayed", cell_frame_count, 24'h004);
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("cell after delay", cell_frame_count, 24'h005);
		// Lock while the cell lags the node by one frame
		@(posedge sys_clk);
		frame_tick <= 1'b1;
		@(posedge sys_clk);
		frame_tick <= 1'b0;
		duplex_mode <= FNC_TIME_DIV;
		sync_port_used <= 1'b1;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("locked low", cell_frame_count[7:0], 24'h06);
		report_and_stop();
	end
endmodule
`default_nettype wire
